// ### include/pport_pkg.sv
// constants, field layouts and state codes of the parallel port block
// assumes one 20 MHz system clock and a synchronous active-low reset
// Contract
// - slave writes captured into two input buffers
// - master reads land in first input buffer
// - width 00 is 8-bit, 01 is 4-bit
// - 4-bit one-phase: full address, then nibble data
// - low latch strobe on address line 0
// - two-phase mode adds high latch strobe phase
// - three-phase mode adds upper latch strobe phase
// - demultiplexed mode: address 9:0 on address lines
// - 16-bit multiplexed: address 14:8 carry data
// - byte and nibble indicators mark transfer portion
// - strobe pins follow mode and strobe-mode bit
package pport_pkg;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CMD_W = 2 + ADDR_W + DATA_W;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_4 = 2'h1;
    localparam logic [1:0] WIDTH_16 = 2'h2;
    localparam logic [1:0] MUX_NONE = 2'h0;
    localparam logic [1:0] MUX_1PH = 2'h1;
    localparam logic [1:0] MUX_2PH = 2'h2;
    localparam logic [1:0] MUX_3PH = 2'h3;
    localparam int POS_LATCH_LOW = 0;
    localparam int POS_LATCH_HIGH = 1;
    localparam int POS_LATCH_UPPER = 2;
    localparam logic [15:0] DIN_RESET = 16'h0000;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ALL = 6'h02,
        S_ALH = 6'h04,
        S_ALU = 6'h08,
        S_DATA = 6'h10,
        S_HOLD = 6'h20
    } state_t;
endpackage

// ### src/parallel_port_address_mux.sv
// parallel port address/data multiplexer with request fifo
// assumes pin inputs already synchronous to sys_clk; modes stable while busy

module pport_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_t;
    fifo_t s;
    fifo_t next_s;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

module parallel_port_address_mux (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic port_enable,
    input wire logic master_mode,
    input wire logic [1:0] port_width_select,
    input wire logic [1:0] address_mux_select,
    input wire logic [1:0] strobe_mode_bit,
    input wire logic ack_wait_enable,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_cs,
    input wire logic [22:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    output logic rd_valid,
    output logic [15:0] data_in_buffer_first,
    output logic [15:0] data_in_buffer_second,
    input wire logic [22:0] ext_address_lines_in,
    output logic [22:0] ext_address_lines_out,
    output logic [22:0] ext_address_lines_oe,
    input wire logic [15:0] ext_data_lines_in,
    output logic [15:0] ext_data_lines_out,
    output logic [15:0] ext_data_lines_oe,
    output logic chip_select_one,
    output logic chip_select_two,
    input wire logic write_strobe_in,
    output logic write_strobe_pin,
    input wire logic read_strobe_in,
    output logic read_strobe_pin,
    output logic strobe_oe,
    output logic byte_indicator,
    output logic nibble_byte_indicator,
    input wire logic ack_input_one,
    input wire logic ack_input_two
);
    typedef struct packed {
        pport_pkg::state_t state;
        logic wr;
        logic cs;
        logic [22:0] addr;
        logic [15:0] data;
        logic half;
        logic [22:0] a_out;
        logic [22:0] a_oe;
        logic [15:0] d_out;
        logic [15:0] d_oe;
        logic cs1;
        logic cs2;
        logic wr_pin;
        logic rd_pin;
        logic st_oe;
        logic byte_ind;
        logic nib_ind;
        logic [15:0] din1;
        logic [15:0] din2;
        logic rd_valid;
        logic wr_prev;
    } port_t;
    port_t s;
    port_t next_s;

    logic f_valid;
    logic f_pop;
    logic [pport_pkg::CMD_W-1:0] f_data;
    logic w4;
    logic w16;
    logic sm;
    logic ack_sel;
    logic slave_wr;

    // depth gives software room while the bus runs slow phases
    pport_fifo #(.WIDTH(pport_pkg::CMD_W), .DEPTH(pport_pkg::FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_write, cmd_cs, cmd_addr, cmd_data}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    assign w4 = (port_width_select == pport_pkg::WIDTH_4);
    assign w16 = (port_width_select == pport_pkg::WIDTH_16);
    assign sm = s.cs ? strobe_mode_bit[1] : strobe_mode_bit[0];
    assign ack_sel = s.cs ? ack_input_two : ack_input_one;
    assign f_pop = (s.state == pport_pkg::S_IDLE) && port_enable && master_mode;
    assign slave_wr = port_enable && !master_mode && write_strobe_in
        && !s.wr_prev;

    always_comb begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        next_s.wr_prev = write_strobe_in;
        if (slave_wr) begin
            // external master write is taken on a rising write_strobe_in edge sampled by sys_clk
            if (!ext_address_lines_in[0]) begin
                next_s.din1 = {8'h00, ext_data_lines_in[7:0]};
            end else begin
                next_s.din2 = {8'h00, ext_data_lines_in[7:0]};
            end
        end
        case (s.state)
            pport_pkg::S_IDLE: begin
                if (f_pop && f_valid) begin
                    {next_s.wr, next_s.cs, next_s.addr, next_s.data} = f_data;
                    next_s.half = 1'b0;
                    if (address_mux_select == pport_pkg::MUX_NONE) begin
                        next_s.state = pport_pkg::S_DATA;
                    end else begin
                        next_s.state = pport_pkg::S_ALL;
                    end
                end
            end
            pport_pkg::S_ALL: begin
                if (address_mux_select[1]) begin
                    next_s.state = pport_pkg::S_ALH;
                end else begin
                    next_s.state = pport_pkg::S_DATA;
                end
            end
            pport_pkg::S_ALH: begin
                if (address_mux_select == pport_pkg::MUX_3PH) begin
                    next_s.state = pport_pkg::S_ALU;
                end else begin
                    next_s.state = pport_pkg::S_DATA;
                end
            end
            pport_pkg::S_ALU: begin
                next_s.state = pport_pkg::S_DATA;
            end
            pport_pkg::S_DATA: begin
                if (!ack_wait_enable || ack_sel) begin
                    next_s.state = pport_pkg::S_HOLD;
                    if (!s.wr) begin
                        if (w4 && s.half) begin
                            next_s.din1[7:4] = ext_data_lines_in[3:0];
                        end else if (w4) begin
                            next_s.din1 = {12'h000, ext_data_lines_in[3:0]};
                        end else if (!w16) begin
                            next_s.din1 = {8'h00, ext_data_lines_in[7:0]};
                        end else if (address_mux_select != 2'h0) begin
                            next_s.din1 = {ext_data_lines_in[15],
                                ext_address_lines_in[14:8],
                                ext_data_lines_in[7:0]};
                        end else begin
                            next_s.din1 = ext_data_lines_in;
                        end
                    end
                end
            end
            pport_pkg::S_HOLD: begin
                if (w4 && !s.half) begin
                    next_s.half = 1'b1;
                    next_s.state = pport_pkg::S_DATA;
                end else begin
                    next_s.state = pport_pkg::S_IDLE;
                    next_s.rd_valid = !s.wr;
                end
            end
            default: begin
                next_s.state = pport_pkg::S_IDLE;
            end
        endcase

        // pins follow the state being entered so they leave a flop
        next_s.a_out = '0;
        next_s.a_oe = '0;
        next_s.d_out = '0;
        next_s.d_oe = '0;
        next_s.wr_pin = 1'b0;
        next_s.rd_pin = 1'b0;
        next_s.byte_ind = 1'b0;
        next_s.nib_ind = 1'b0;
        next_s.st_oe = port_enable && master_mode;
        next_s.cs1 = (next_s.state != pport_pkg::S_IDLE) && !next_s.cs;
        next_s.cs2 = (next_s.state != pport_pkg::S_IDLE) && next_s.cs;
        if (port_enable && master_mode) begin
            next_s.a_oe[9:0] = 10'h3FF;
        end
        if (w4 && address_mux_select != pport_pkg::MUX_NONE
                && next_s.state != pport_pkg::S_IDLE) begin
            if (address_mux_select == pport_pkg::MUX_3PH) begin
                next_s.a_out[9:8] = next_s.addr[13:12];
            end else begin
                next_s.a_out[9:8] = next_s.addr[9:8];
            end
        end
        case (next_s.state)
            pport_pkg::S_ALL: begin
                next_s.a_out[pport_pkg::POS_LATCH_LOW] = 1'b1;
                next_s.d_oe[7:0] = 8'hFF;
                if (w4 && address_mux_select != pport_pkg::MUX_1PH) begin
                    next_s.d_out[3:0] = next_s.addr[3:0];
                end else begin
                    next_s.d_out[7:0] = next_s.addr[7:0];
                end
            end
            pport_pkg::S_ALH: begin
                next_s.a_out[pport_pkg::POS_LATCH_HIGH] = 1'b1;
                next_s.d_oe[7:0] = 8'hFF;
                if (w4) begin
                    next_s.d_out[3:0] = next_s.addr[7:4];
                end else begin
                    next_s.d_out[7:0] = next_s.addr[15:8];
                end
            end
            pport_pkg::S_ALU: begin
                next_s.a_out[pport_pkg::POS_LATCH_UPPER] = 1'b1;
                next_s.d_oe[7:0] = 8'hFF;
                if (w4) begin
                    next_s.d_out[3:0] = next_s.addr[11:8];
                end else begin
                    next_s.d_out[6:0] = next_s.addr[22:16];
                end
            end
            pport_pkg::S_DATA: begin
                if (address_mux_select == pport_pkg::MUX_NONE) begin
                    next_s.a_out[9:0] = next_s.addr[9:0];
                end
                if (sm) begin
                    next_s.rd_pin = !next_s.wr;
                    next_s.wr_pin = 1'b1;
                end else begin
                    next_s.rd_pin = !next_s.wr;
                    next_s.wr_pin = next_s.wr;
                end
                next_s.byte_ind = w16;
                next_s.nib_ind = w4 ? next_s.half : 1'b1;
                if (next_s.wr && w4) begin
                    next_s.d_oe[3:0] = 4'hF;
                    next_s.d_out[3:0] = next_s.half ? next_s.data[7:4]
                        : next_s.data[3:0];
                end else if (next_s.wr) begin
                    next_s.d_oe[7:0] = 8'hFF;
                    next_s.d_out[7:0] = next_s.data[7:0];
                end
                if (next_s.wr && w16 && address_mux_select == 2'h0) begin
                    next_s.d_oe[15:8] = 8'hFF;
                    next_s.d_out[15:8] = next_s.data[15:8];
                end else if (next_s.wr && w16) begin
                    next_s.a_oe[14:8] = 7'h7F;
                    next_s.a_out[14:8] = next_s.data[14:8];
                    next_s.d_oe[15] = 1'b1;
                    next_s.d_out[15] = next_s.data[15];
                end
            end
            default: begin
                next_s.d_oe = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            s <= '{state: pport_pkg::S_IDLE, din1: pport_pkg::DIN_RESET,
                din2: pport_pkg::DIN_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign rd_valid = s.rd_valid;
    assign data_in_buffer_first = s.din1;
    assign data_in_buffer_second = s.din2;
    assign ext_address_lines_out = s.a_out;
    assign ext_address_lines_oe = s.a_oe;
    assign ext_data_lines_out = s.d_out;
    assign ext_data_lines_oe = s.d_oe;
    assign chip_select_one = s.cs1;
    assign chip_select_two = s.cs2;
    assign write_strobe_pin = s.wr_pin;
    assign read_strobe_pin = s.rd_pin;
    assign strobe_oe = s.st_oe;
    assign byte_indicator = s.byte_ind;
    assign nibble_byte_indicator = s.nib_ind;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence seq_three_phase;
        s.state == pport_pkg::S_ALH ##1 s.state == pport_pkg::S_ALU
            ##1 s.state == pport_pkg::S_DATA;
    endsequence

    a_phase_order: assert property (
        s.state == pport_pkg::S_ALL && $stable(address_mux_select)
            && address_mux_select == pport_pkg::MUX_3PH |=> seq_three_phase)
        else $error("address phases out of order");
    a_data_after_addr: assert property (
        $rose(s.state == pport_pkg::S_DATA) && !s.half
            && address_mux_select != pport_pkg::MUX_NONE
            |-> $past(s.state) != pport_pkg::S_IDLE)
        else $error("data phase before address phases");
    a_low_latch: assert property (
        s.state == pport_pkg::S_ALL |-> s.a_out[2:0] == 3'h1
            && s.a_oe[0] && s.d_oe[3:0] == 4'hF)
        else $error("low latch strobe wrong");
    a_high_latch: assert property (
        s.state == pport_pkg::S_ALH |-> s.a_out[2:0] == 3'h2
            && $past(s.state) == pport_pkg::S_ALL)
        else $error("high latch strobe wrong");
    a_upper_latch: assert property (
        s.state == pport_pkg::S_ALU |-> s.a_out[2:0] == 3'h4
            && $past(s.state, 2) == pport_pkg::S_ALL)
        else $error("upper latch strobe wrong");
    a_demux_addr: assert property (
        s.state == pport_pkg::S_DATA && address_mux_select == 2'h0
            |-> s.a_out[9:0] == s.addr[9:0])
        else $error("demux address not on lines");
    a_nibble_lanes: assert property (
        s.state == pport_pkg::S_DATA && w4 |-> s.d_oe[15:4] == 12'h000
            && s.nib_ind == s.half)
        else $error("4-bit data lanes wrong");
    a_wide_mux: assert property (
        s.state == pport_pkg::S_DATA && w16 && s.wr
            && address_mux_select != 2'h0 |-> s.a_oe[14:8] == 7'h7F)
        else $error("wide data not on address lines");
    a_read_hold: assert property (
        s.state == pport_pkg::S_DATA && !s.wr && !w4 && !w16
            && !ack_wait_enable
            |=> s.din1[7:0] == $past(ext_data_lines_in[7:0]) ##1 s.rd_valid)
        else $error("read data not held in first buffer");
    a_slave_capture: assert property (
        slave_wr && !ext_address_lines_in[0]
            |=> s.din1 == {8'h00, $past(ext_data_lines_in[7:0])})
        else $error("slave write not captured");
    a_strobe_mode: assert property (
        s.state == pport_pkg::S_DATA && sm |-> s.wr_pin && s.rd_pin == !s.wr)
        else $error("enable strobe mode wrong");
endmodule

// ### dv/pport_far_memory.sv
// far-side model: byte memory behind the multiplexed parallel port
// assumes the bench feeds it the port's width and mux setup and its pins
module pport_far_memory (
    input wire logic sys_clk,
    input wire logic four_bit,
    input wire logic [1:0] mux,
    input wire logic [1:0] sm,
    input wire logic [3:0] ack_delay,
    input wire logic [22:0] ao,
    input wire logic [22:0] aoe,
    input wire logic [15:0] dout,
    input wire logic cs1,
    input wire logic cs2,
    input wire logic wr_pin,
    input wire logic rd_pin,
    input wire logic nib,
    output logic [15:0] din,
    output logic ack1,
    output logic ack2
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [int];
    logic [22:0] key = 23'h000000;
    logic [15:0] last = 16'h0000;
    logic [3:0] cnt = 4'h0;
    logic [7:0] rbyte;
    logic sel, msm, rd_act, wr_act, ok;
    int k;
    assign sel = cs1 | cs2;
    assign msm = cs2 ? sm[1] : sm[0];
    assign rd_act = sel && (msm ? (wr_pin && rd_pin) : rd_pin);
    assign wr_act = sel && (msm ? (wr_pin && !rd_pin) : wr_pin);
    assign ok = (rd_act || wr_act) && cnt >= ack_delay;
    assign ack1 = cs1 && ok;
    assign ack2 = cs2 && ok;
    assign k = (mux == 2'h0) ? int'(ao[9:0]) : int'(key);
    always_comb begin
        rbyte = mem.exists(k) ? mem[k] : (k[7:0] ^ 8'h5A);
        // released lines churn so a stale value is never mistaken for data
        din = ~last;
        if (rd_act && four_bit)
            din = {~last[15:4], nib ? rbyte[7:4] : rbyte[3:0]};
        else if (rd_act)
            din = {~last[15:8], rbyte};
    end
    always @(posedge sys_clk) begin
        last <= din;
        cnt <= (rd_act || wr_act) ? cnt + 4'h1 : 4'h0;
        if (mux != 2'h0 && aoe[0] && ao[0]) begin
            if (!four_bit)
                key <= {15'h0000, dout[7:0]};
            else if (mux == 2'h1)
                key <= {13'h0000, ao[9:8], dout[7:0]};
            else if (mux == 2'h2)
                key <= {13'h0000, ao[9:8], 4'h0, dout[3:0]};
            else
                key <= {9'h000, ao[9:8], 8'h00, dout[3:0]};
        end
        if (mux[1] && aoe[1] && ao[1]) begin
            if (four_bit)
                key[7:4] <= dout[3:0];
            else
                key[15:8] <= dout[7:0];
        end
        if (mux == 2'h3 && aoe[2] && ao[2]) begin
            if (four_bit)
                key[11:8] <= dout[3:0];
            else
                key[22:16] <= dout[6:0];
        end
        if (wr_act && four_bit && nib)
            mem[k][7:4] = dout[3:0];
        else if (wr_act && four_bit)
            mem[k][3:0] = dout[3:0];
        else if (wr_act)
            mem[k] = dout[7:0];
    end
endmodule

// ### dv/test_parallel_port_address_mux.sv
// self-checking bench: write/read traffic in every width and mux mode
// assumes the far-side memory model and the design's own assertions
module test_parallel_port_address_mux;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, resetn = 1'b0, port_enable = 1'b0;
    logic master_mode = 1'b1, ack_wait = 1'b0, cmd_valid = 1'b0;
    logic cmd_write = 1'b0, cmd_cs = 1'b0, slave_a0 = 1'b0, wr_in = 1'b0;
    logic [1:0] width = 2'h0, mux = 2'h0, sm = 2'h0;
    logic [22:0] cmd_addr = 23'h000000;
    logic [15:0] cmd_data = 16'h0000, slave_d = 16'h0000, seed = 16'h0033;
    logic [3:0] dly = 4'h0;
    logic cmd_ready, rd_valid, cs1, cs2, wr_pin, rd_pin, s_oe, be1, be0;
    logic ack1, ack2;
    logic [15:0] buf1, buf2, dout, doe, p_din, pins_in;
    logic [22:0] ao, aoe;
    logic [7:0] exp_mem [int];
    logic [7:0] exp_q [$];
    int n_mismatch = 0;
    int n_tests = 0;
    assign pins_in = master_mode ? p_din : slave_d;
    always #25 sys_clk = ~sys_clk;
    parallel_port_address_mux DUT (.sys_clk(sys_clk), .resetn(resetn),
        .port_enable(port_enable), .master_mode(master_mode),
        .port_width_select(width), .address_mux_select(mux),
        .strobe_mode_bit(sm), .ack_wait_enable(ack_wait),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_cs(cmd_cs), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .rd_valid(rd_valid), .data_in_buffer_first(buf1),
        .data_in_buffer_second(buf2),
        .ext_address_lines_in({22'h000000, slave_a0}),
        .ext_address_lines_out(ao), .ext_address_lines_oe(aoe),
        .ext_data_lines_in(pins_in), .ext_data_lines_out(dout),
        .ext_data_lines_oe(doe), .chip_select_one(cs1),
        .chip_select_two(cs2), .write_strobe_in(wr_in),
        .write_strobe_pin(wr_pin), .read_strobe_in(1'b0),
        .read_strobe_pin(rd_pin), .strobe_oe(s_oe), .byte_indicator(be1),
        .nibble_byte_indicator(be0), .ack_input_one(ack1),
        .ack_input_two(ack2));
    pport_far_memory far (.sys_clk(sys_clk), .four_bit(width == 2'h1),
        .mux(mux), .sm(sm), .ack_delay(dly), .ao(ao), .aoe(aoe),
        .dout(dout), .cs1(cs1), .cs2(cs2), .wr_pin(wr_pin), .rd_pin(rd_pin),
        .nib(be0), .din(p_din), .ack1(ack1), .ack2(ack2));

    function logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction

    // address bits that reach the far side in the current mode
    function automatic int key_of(logic [22:0] a);
        if (width == 2'h1)
            return (mux == 2'h3) ? int'(a[13:0]) : int'(a[9:0]);
        case (mux)
            2'h0: return int'(a[9:0]);
            2'h1: return int'(a[7:0]);
            2'h2: return int'(a[15:0]);
            default: return int'(a);
        endcase
    endfunction

    task automatic check(string what, logic [15:0] expv, logic [15:0] got);
        n_tests++;
        if (got !== expv) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic send(logic wr, logic [22:0] a, logic [7:0] d);
        logic [15:0] r;
        int k;
        r = rnd();
        @(posedge sys_clk);
        k = key_of(a);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_cs <= r[0];
        cmd_addr <= a;
        cmd_data <= {r[15:8], d};
        if (wr)
            exp_mem[k] = d;
        else
            exp_q.push_back(exp_mem.exists(k) ? exp_mem[k] : k[7:0] ^ 8'h5A);
        do @(negedge sys_clk); while (cmd_ready !== 1'b1);
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic idle();
        int k;
        k = 0;
        while (k < 12) begin
            @(negedge sys_clk);
            if (exp_q.size() == 0 && cs1 === 1'b0 && cs2 === 1'b0)
                k++;
            else
                k = 0;
        end
    endtask

    always @(negedge sys_clk) begin
        if (rd_valid === 1'b1 && exp_q.size() == 0)
            check("unexpected read", 16'h0000, 16'h0001);
        else if (rd_valid === 1'b1)
            check("read data", {8'h00, exp_q.pop_front()}, {8'h00, buf1[7:0]});
        // read data phase: lanes released, byte indicator and strobe enable driven
        if ((cs1 === 1'b1 || cs2 === 1'b1) && rd_pin === 1'b1) begin
            check("read lanes", 16'h0000, doe);
            check("byte ind", 16'(width == 2'h2), 16'(be1));
            check("strobe enable", 16'h0001, 16'(s_oe));
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        logic [22:0] a [4];
        logic [15:0] t, first;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        check("ready after reset", 16'h0001, {15'h0000, cmd_ready});
        check("selects after reset", 16'h0000, {14'h0000, cs2, cs1});
        check("strobe enable after reset", 16'h0000, 16'(s_oe));
        @(posedge sys_clk);
        port_enable <= 1'b1;
        // every width, mux, strobe mode and ack option
        for (int m = 0; m < 12; m++) begin
            @(posedge sys_clk);
            width <= m[3] ? 2'h2 : {1'b0, m[2]};
            mux <= m[1:0];
            sm <= {m[0], m[1]};
            ack_wait <= m[0];
            dly <= m[1] ? 4'h3 : 4'h0;
            for (int i = 0; i < 4; i++) begin
                t = rnd();
                a[i] = {t[6:0], rnd()};
            end
            for (int i = 0; i < 3; i++) begin
                t = rnd();
                send(1'b1, a[i], t[7:0]);
            end
            for (int i = 0; i < 4; i++)
                send(1'b0, a[i], 8'h00);
            idle();
        end
        // fill the queue while disabled, then drain against a slow far side
        @(posedge sys_clk);
        port_enable <= 1'b0;
        width <= 2'h0;
        mux <= 2'h3;
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            send(i[0], {t[6:0], rnd()}, t[15:8]);
        end
        @(negedge sys_clk);
        check("full queue ready", 16'h0000, {15'h0000, cmd_ready});
        @(posedge sys_clk);
        port_enable <= 1'b1;
        send(1'b0, a[0], 8'h00);
        idle();
        check("drained queue ready", 16'h0001, {15'h0000, cmd_ready});
        // slave writes into both input buffers
        @(posedge sys_clk);
        master_mode <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            t = rnd();
            @(posedge sys_clk);
            slave_a0 <= i[0];
            slave_d <= t;
            wr_in <= 1'b1;
            @(posedge sys_clk);
            wr_in <= 1'b0;
            @(posedge sys_clk);
            @(negedge sys_clk);
            if (i == 0)
                first = {8'h00, t[7:0]};
            if (i == 0)
                check("slave first", first, buf1);
            else
                check("slave second", {8'h00, t[7:0]}, buf2);
        end
        check("slave first kept", first, buf1);
        check("slave strobe enable", 16'h0000, 16'(s_oe));
        close_out();
    end
endmodule
